// ===== hdl/ulr_regs.sv
// control register tail of the usb line interface with line-state filter
`timescale 1ns/1ps
// Functional notes
// - a 16-bit mask marks endpoints whose number goes to the receive port ored with 0x10.
// - bit 18 of transceiver control disables pulldowns on both port groups when set.
// - an automatic resume caused by se0 sets bit 13, which stays until software writes 0.
// - an automatic resume caused by a k state sets bit 12, which stays until software writes 0.
// - a line-state change propagates only after 2 to the power of bits 11:8 clocks.
// - bit 7 enables suspend and automatic resume from it; while it is clear, suspend requests are ignored.
// - bits 6:4 drive the three transceiver configuration pins directly.
// - the power signalling register holds 8 data bits and a valid bit, both reset to zero.
// - the last token endpoint number is recorded with a valid flag.
module ulr_regs #(
  parameter int FILT_CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire ulr_pkg::ulr_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic irq,
  input wire logic [1:0] line_state_raw,
  input wire logic suspend_req,
  input wire ulr_pkg::ulr_token_t token_in,
  output logic [4:0] rx_endpoint,
  output logic [1:0] line_state_filt,
  output logic resume_pulse,
  output logic pulldown_dis_group_a,
  output logic pulldown_dis_group_b,
  output logic [2:0] transceiver_config_pins,
  output logic [7:0] power_data,
  output logic power_valid
);
  import ulr_pkg::*;

  // ****************************************
  // register storage
  // ****************************************
  logic [15:0] ep_mask_ff;
  logic [31:0] otg_mask_ff;
  logic [8:0] power_ff;
  logic pulldown_dis_ff;
  logic resume_se0_ff;
  logic resume_k_ff;
  logic [3:0] filt_log2_ff;
  logic suspend_en_ff;
  logic [2:0] conf_ff;
  logic [1:0] irq_status_ff;
  logic [1:0] irq_mask_ff;
  logic [31:0] rdata_ff;
  ulr_token_t last_token_ff;
  logic [4:0] rx_ep_ff;

  // per-register write strobes and hardware set events
  logic wr_ep_mask;
  logic wr_otg_mask;
  logic wr_power;
  logic wr_xc;
  logic wr_irq_mask;
  logic set_se0;
  logic set_k;

  // one write strobe per writable register; unmapped offsets match none of them
  assign wr_ep_mask = bus_req.wr && (bus_req.addr == OFS_EP_SPECIAL_MASK);
  assign wr_otg_mask = bus_req.wr && (bus_req.addr == OFS_OTG_FLAG_MASK);
  assign wr_power = bus_req.wr && (bus_req.addr == OFS_POWER_SIGNAL);
  assign wr_xc = bus_req.wr && (bus_req.addr == OFS_XCVR_CONTROL);
  assign wr_irq_mask = bus_req.wr && (bus_req.addr == OFS_IRQ_MASK);

  // endpoint special mask; the upper half of the word is reserved
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ep_mask_ff <= RST_EP_MASK;
    end else if (wr_ep_mask) begin
      ep_mask_ff <= bus_req.wdata[15:0];
    end
  end

  // otg flag mask, full word, no side effects
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      otg_mask_ff <= RST_OTG_MASK;
    end else if (wr_otg_mask) begin
      otg_mask_ff <= bus_req.wdata;
    end
  end

  // power signalling data and valid flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      power_ff <= RST_POWER;
    end else if (wr_power) begin
      power_ff <= bus_req.wdata[PWR_VALID_BIT:0];
    end
  end

  // transceiver control fields; the cause flags live with their set logic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulldown_dis_ff <= 1'b0;
      filt_log2_ff <= RST_NIBBLE;
      suspend_en_ff <= 1'b0;
      conf_ff <= RST_CONF;
    end else if (wr_xc) begin
      pulldown_dis_ff <= bus_req.wdata[XC_PULLDOWN_DIS_BIT];
      filt_log2_ff <= bus_req.wdata[XC_FILT_LSB +: 4];
      suspend_en_ff <= bus_req.wdata[XC_SUSPEND_EN_BIT];
      conf_ff <= bus_req.wdata[XC_CONF_LSB +: 3];
    end
  end

  // interrupt mask, same layout as the status
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_mask_ff <= RST_IRQ;
    end else if (wr_irq_mask) begin
      irq_mask_ff <= bus_req.wdata[1:0];
    end
  end

  // ****************************************
  // line-state filter
  // ****************************************
  logic [1:0] ls_s1_ff;
  logic [1:0] ls_s2_ff;
  logic [1:0] ls_s3_ff;
  logic [1:0] ls_cand_ff;
  logic [1:0] ls_filt_ff;
  logic [FILT_CNT_W-1:0] filt_cnt_ff;
  logic [FILT_CNT_W-1:0] filt_target;

  // three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ls_s1_ff <= LS_SE0;
      ls_s2_ff <= LS_SE0;
      ls_s3_ff <= LS_SE0;
    end else begin
      ls_s1_ff <= line_state_raw;
      ls_s2_ff <= ls_s1_ff;
      ls_s3_ff <= ls_s2_ff;
    end
  end

  // 2**n clocks; a shift past the counter width saturates to all ones
  assign filt_target = (32'(filt_log2_ff) >= FILT_CNT_W) ? '1 :
                       FILT_CNT_W'(1) << filt_log2_ff;

  // restart on any change of the candidate, forward once it held the full count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ls_cand_ff <= LS_SE0;
      ls_filt_ff <= LS_SE0;
      filt_cnt_ff <= FILT_CNT_W'(RST_FILT_CNT);
    end else if (ls_s2_ff == ls_s3_ff && ls_s3_ff != ls_cand_ff) begin
      ls_cand_ff <= ls_s3_ff;
      filt_cnt_ff <= FILT_CNT_W'(1);
    end else if (ls_cand_ff != ls_filt_ff) begin
      if (filt_cnt_ff >= filt_target) begin
        ls_filt_ff <= ls_cand_ff;
      end else begin
        filt_cnt_ff <= filt_cnt_ff + FILT_CNT_W'(1);
      end
    end
  end

  // ****************************************
  // suspend controller
  // ****************************************
  ulr_susp_t susp_ff;
  logic resume_pulse_ff;

  // suspends only when enabled; se0 or k on the filtered line, or a cleared enable, ends suspend
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      susp_ff <= ULR_ACTIVE;
    end else begin
      case (susp_ff)
        ULR_ACTIVE: begin
          if (suspend_req && suspend_en_ff) begin
            susp_ff <= ULR_SUSPENDED;
          end
        end
        ULR_SUSPENDED: begin
          if (!suspend_en_ff) begin
            susp_ff <= ULR_ACTIVE;
          end else if (ls_filt_ff == LS_SE0 || ls_filt_ff == LS_K) begin
            susp_ff <= ULR_ACTIVE;
          end
        end
        default: susp_ff <= ULR_ACTIVE;
      endcase
    end
  end

  // one-cycle pulse on the edge that leaves suspend for a line event
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resume_pulse_ff <= 1'b0;
    end else begin
      resume_pulse_ff <= set_se0 || set_k;
    end
  end

  // wake causes; clearing the enable while suspended wakes with no cause
  assign set_se0 = (susp_ff == ULR_SUSPENDED) && suspend_en_ff && (ls_filt_ff == LS_SE0);
  assign set_k = (susp_ff == ULR_SUSPENDED) && suspend_en_ff && (ls_filt_ff == LS_K);

  // se0 cause flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resume_se0_ff <= 1'b0;
    end else if (set_se0) begin
      resume_se0_ff <= 1'b1;
    end else if (wr_xc && !bus_req.wdata[XC_RESUME_SE0_BIT]) begin
      resume_se0_ff <= 1'b0;
    end
  end

  // k cause flag: writing 1 leaves it alone, so software may rewrite the word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resume_k_ff <= 1'b0;
    end else if (set_k) begin
      resume_k_ff <= 1'b1;
    end else if (wr_xc && !bus_req.wdata[XC_RESUME_K_BIT]) begin
      resume_k_ff <= 1'b0;
    end
  end

  // ****************************************
  // endpoint tracking
  // ****************************************
  // last token seen, readable at the endpoint offset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_token_ff <= '0;
    end else if (token_in.valid) begin
      last_token_ff <= token_in;
    end
  end

  // receive port number, tagged for endpoints marked special
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_ep_ff <= 5'h00;
    end else if (token_in.valid) begin
      rx_ep_ff <= ep_mask_ff[token_in.ep] ? ({1'b0, token_in.ep} | EP_SPECIAL_OR)
                                          : {1'b0, token_in.ep};
    end
  end

  // ****************************************
  // interrupts and read-back
  // ****************************************
  // a status read doubles as its clear strobe
  logic rd_irq;
  assign rd_irq = bus_req.rd && (bus_req.addr == OFS_IRQ_STATUS);

  // sticky status cleared by reading it; a new event in that cycle survives
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status_ff <= RST_IRQ;
    end else begin
      irq_status_ff <= (rd_irq ? 2'h0 : irq_status_ff) | {set_k, set_se0};
    end
  end

  // read data in the cycle after the strobe, zero for unmapped offsets
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= 32'h0000_0000;
      if (bus_req.rd) begin
        case (bus_req.addr)
          OFS_ENDPOINT: rdata_ff <= {27'h0, last_token_ff.valid, last_token_ff.ep};
          OFS_EP_SPECIAL_MASK: rdata_ff <= {16'h0, ep_mask_ff};
          OFS_OTG_FLAG_MASK: rdata_ff <= otg_mask_ff;
          OFS_POWER_SIGNAL: rdata_ff <= {23'h0, power_ff};
          OFS_XCVR_CONTROL: rdata_ff <= {13'h0, pulldown_dis_ff, 4'h0, resume_se0_ff,
                                         resume_k_ff, filt_log2_ff, suspend_en_ff,
                                         conf_ff, 4'h0};
          OFS_IRQ_STATUS: rdata_ff <= {30'h0, irq_status_ff};
          OFS_IRQ_MASK: rdata_ff <= {30'h0, irq_mask_ff};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pins come straight from flops; the irq level is the only gate here
  assign bus_rdata = rdata_ff;
  assign irq = |(irq_status_ff & irq_mask_ff);
  assign rx_endpoint = rx_ep_ff;
  assign line_state_filt = ls_filt_ff;
  assign resume_pulse = resume_pulse_ff;
  assign pulldown_dis_group_a = pulldown_dis_ff;
  assign pulldown_dis_group_b = pulldown_dis_ff;
  assign transceiver_config_pins = conf_ff;
  assign power_data = power_ff[7:0];
  assign power_valid = power_ff[PWR_VALID_BIT];
endmodule : ulr_regs

// ===== hdl/ulr_pkg.sv
// package for the usb line interface control register tail
package ulr_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_EP_SPECIAL_MASK = 8'h34;
  localparam logic [7:0] OFS_OTG_FLAG_MASK = 8'h38;
  localparam logic [7:0] OFS_POWER_SIGNAL = 8'h3c;
  localparam logic [7:0] OFS_XCVR_CONTROL = 8'h40;
  localparam logic [7:0] OFS_ENDPOINT = 8'h30;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
  // ****************************************
  // field positions
  // ****************************************
  localparam int PWR_VALID_BIT = 8;
  localparam int XC_PULLDOWN_DIS_BIT = 18;
  localparam int XC_RESUME_SE0_BIT = 13;
  localparam int XC_RESUME_K_BIT = 12;
  localparam int XC_FILT_LSB = 8;
  localparam int XC_SUSPEND_EN_BIT = 7;
  localparam int XC_CONF_LSB = 4;
  localparam int EP_VALID_BIT = 4;
  localparam logic [4:0] EP_SPECIAL_OR = 5'h10;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_EP_MASK = 16'h0000;
  localparam logic [31:0] RST_OTG_MASK = 32'h0000_0000;
  localparam logic [8:0] RST_POWER = 9'h000;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [2:0] RST_CONF = 3'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [15:0] RST_FILT_CNT = 16'h0000;
  // usb line state encodings
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
  // irq status layout: bit0 se0 resume, bit1 k resume
  localparam int IRQ_SE0 = 0;
  localparam int IRQ_K = 1;

  typedef enum logic [1:0] {
    ULR_ACTIVE = 2'b00,
    ULR_SUSPENDED = 2'b01
  } ulr_susp_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ulr_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
  } ulr_token_t;
endpackage : ulr_pkg

// ===== verification/ulr_chk_props.sv
// port assertions for the usb line interface register tail
`timescale 1ns/1ps
module ulr_chk #(
  parameter int FILT_CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire ulr_pkg::ulr_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic irq,
  input wire logic [1:0] line_state_raw,
  input wire logic suspend_req,
  input wire ulr_pkg::ulr_token_t token_in,
  input wire logic [4:0] rx_endpoint,
  input wire logic [1:0] line_state_filt,
  input wire logic resume_pulse,
  input wire logic pulldown_dis_group_a,
  input wire logic pulldown_dis_group_b,
  input wire logic [2:0] transceiver_config_pins,
  input wire logic [7:0] power_data,
  input wire logic power_valid
);
  import ulr_pkg::*;
  // ************
  // properties
  // ************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_pd_pair: assert property (pulldown_dis_group_a == pulldown_dis_group_b)
    else $error("pulldown groups differ");
  a_ctl_cause: assert property ($changed({pulldown_dis_group_a, transceiver_config_pins})
    |-> $past(bus_req.wr) && $past(bus_req.addr) == OFS_XCVR_CONTROL)
    else $error("control pins moved without a write");
  a_ctl_read: assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFS_XCVR_CONTROL
    |-> bus_rdata[6:4] == transceiver_config_pins && bus_rdata[18] == pulldown_dis_group_a)
    else $error("control read disagrees with pins");
  a_pwr_cause: assert property ($changed({power_valid, power_data})
    |-> $past(bus_req.wr) && $past(bus_req.addr) == OFS_POWER_SIGNAL)
    else $error("power outputs moved without a write");
  a_pwr_read: assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFS_POWER_SIGNAL
    |-> bus_rdata == {23'h0, power_valid, power_data})
    else $error("power read disagrees with outputs");
  a_ep_value: assert property (token_in.valid |=> rx_endpoint[3:0] == $past(token_in.ep))
    else $error("endpoint number not passed on");
  a_ep_hold: assert property (!$past(token_in.valid) |-> $stable(rx_endpoint))
    else $error("endpoint moved without a token");
  a_resume_one: assert property (resume_pulse |=> !resume_pulse)
    else $error("resume pulse longer than one cycle");
  // a forward needs a finished count: neither of the two newest synchroniser pairs
  // seen by the filter may show some other state at the forwarding edge
  a_filt_settle: assert property ($changed(line_state_filt)
    |-> !($past(line_state_raw, 3) == $past(line_state_raw, 4)
          && $past(line_state_raw, 3) != line_state_filt)
        && !($past(line_state_raw, 4) == $past(line_state_raw, 5)
          && $past(line_state_raw, 4) != line_state_filt))
    else $error("filtered state moved while raw held another state");
endmodule : ulr_chk

bind ulr_regs ulr_chk #(.FILT_CNT_W(FILT_CNT_W)) u_chk (.sys_clk(sys_clk), .rst(rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq), .line_state_raw(line_state_raw),
  .suspend_req(suspend_req), .token_in(token_in), .rx_endpoint(rx_endpoint),
  .line_state_filt(line_state_filt), .resume_pulse(resume_pulse),
  .pulldown_dis_group_a(pulldown_dis_group_a), .pulldown_dis_group_b(pulldown_dis_group_b),
  .transceiver_config_pins(transceiver_config_pins), .power_data(power_data),
  .power_valid(power_valid));

// ===== verification/ulr_line_model.sv
// transceiver and host side model: line state and received tokens
`timescale 1ns/1ps
module ulr_line_model (
  input wire logic sys_clk,
  output logic [1:0] line_state_raw,
  output ulr_pkg::ulr_token_t token_in
);
  import ulr_pkg::*;
  // bus starts in se0, no token pending
  initial begin
    line_state_raw = LS_SE0;
    token_in = '0;
  end
  task set_line(input logic [1:0] ls);
    @(posedge sys_clk);
    line_state_raw <= ls;
  endtask : set_line
  // stale endpoint inverted once the strobe drops, so nothing leans on it
  task send_token(input logic [3:0] ep);
    @(posedge sys_clk);
    token_in <= {1'b1, ep};
    @(posedge sys_clk);
    token_in <= {1'b0, ~ep};
  endtask : send_token
endmodule : ulr_line_model

// ===== verification/ulr_regs_test.sv
// self-checking bench for the register tail
`timescale 1ns/1ps
module ulr_regs_test;
  import ulr_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} ulr_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic suspend_req = 1'b0;
  ulr_bus_req_t bus_req = '0;
  ulr_token_t token_in;
  logic [31:0] bus_rdata;
  logic [4:0] rx_endpoint;
  logic [1:0] line_state_raw, line_state_filt;
  logic [2:0] conf;
  logic [7:0] pdat;
  logic irq, resume_pulse, pda, pdb, pval;
  int fails = 0;
  int check_count = 0;
  int pulses = 0;
  ulr_row_t rows [5] = '{'{8'h34, 32'hffff_ffff, 32'h0000_ffff},
    '{8'h38, 32'ha5a5_5a5a, 32'ha5a5_5a5a}, '{8'h3c, 32'hffff_ff5a, 32'h0000_015a},
    '{8'h40, 32'hffff_ffff, 32'h0004_0ff0}, '{8'h50, 32'hffff_ffff, 32'h0000_0000}};
  // ************
  // harness
  // ************
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (resume_pulse === 1'b1) pulses <= pulses + 1;
  ulr_line_model mdl (.sys_clk(sys_clk), .line_state_raw(line_state_raw), .token_in(token_in));
  ulr_regs dut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .irq(irq), .line_state_raw(line_state_raw), .suspend_req(suspend_req),
    .token_in(token_in), .rx_endpoint(rx_endpoint), .line_state_filt(line_state_filt),
    .resume_pulse(resume_pulse), .pulldown_dis_group_a(pda), .pulldown_dis_group_b(pdb),
    .transceiver_config_pins(conf), .power_data(pdat), .power_valid(pval));
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 chk($sformatf("rd %h", a), e, bus_rdata);
  endtask : rd
  task susp();
    @(posedge sys_clk);
    suspend_req <= 1'b1;
    @(posedge sys_clk);
    suspend_req <= 1'b0;
  endtask : susp
  task results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // watchdog: the tests need well under a thousand cycles
  initial begin
    wt(5000);
    fails++;
    results();
  end
  // ************
  // tests
  // ************
  initial begin
    wt(20);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    chk("pins", {1'b1, 1'b1, 3'h7, 1'b1, 8'h5a}, {pda, pdb, conf, pval, pdat});
    $display("test rows done");
    wt(1);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    chk("pins", 32'h0, {pda, pdb, conf, pval, pdat});
    foreach (rows[i]) rd(rows[i].a, 32'h0);
    $display("test reset done");
    wr(OFS_EP_SPECIAL_MASK, 32'h0000_8020);
    mdl.send_token(4'h5);
    #1 chk("ep", 5'h15, rx_endpoint);
    mdl.send_token(4'h4);
    #1 chk("ep", 5'h04, rx_endpoint);
    mdl.send_token(4'hf);
    #1 chk("ep", 5'h1f, rx_endpoint);
    rd(OFS_ENDPOINT, 32'h0000_001f);
    $display("test tokens done");
    // two to the power two clocks of filtering, automatic resume on
    wr(OFS_XCVR_CONTROL, 32'h0000_0280);
    mdl.set_line(LS_J);
    wt(4);
    chk("filt", LS_SE0, line_state_filt);
    wt(8);
    chk("filt", LS_J, line_state_filt);
    mdl.set_line(LS_K);
    wt(2);
    mdl.set_line(LS_J);
    repeat (10) begin
      wt(1);
      #1 chk("filt", LS_J, line_state_filt);
    end
    $display("test filter done");
    wr(OFS_IRQ_MASK, 32'h3);
    susp();
    mdl.set_line(LS_K);
    wt(15);
    chk("pulses", 1, pulses);
    chk("irq", 1'b1, irq);
    rd(OFS_XCVR_CONTROL, 32'h0000_1280);
    rd(OFS_IRQ_STATUS, 32'h2);
    chk("irq", 1'b0, irq);
    wr(OFS_XCVR_CONTROL, 32'h0000_0280);
    rd(OFS_XCVR_CONTROL, 32'h0000_0280);
    wr(OFS_IRQ_MASK, 32'h0);
    mdl.set_line(LS_J);
    wt(12);
    susp();
    mdl.set_line(LS_SE0);
    wt(15);
    chk("pulses", 2, pulses);
    chk("irq", 1'b0, irq);
    rd(OFS_XCVR_CONTROL, 32'h0000_2280);
    rd(OFS_IRQ_STATUS, 32'h1);
    $display("test resume done");
    results();
  end
endmodule : ulr_regs_test
